// file: core/cis_pkg.sv
// Constants shared by the comparator input selection block.
// Assumes an 8-bit register port with a 3-bit word address.
package cis_pkg;

    // Register port widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets (word addresses)
    localparam logic [2:0] OFF_CONVERTER_CONTROL_A = 3'h0;
    localparam logic [2:0] OFF_CONVERTER_CONTROL_B = 3'h1;
    localparam logic [2:0] OFF_CHANNEL_SELECT_REGISTER = 3'h2;
    localparam logic [2:0] OFF_COMPARATOR_CONTROL_STATUS = 3'h3;
    localparam logic [2:0] OFF_SELECT_STATUS = 3'h4;

    // Field positions
    localparam int POS_CONVERTER_ENABLE = 7;
    localparam int POS_COMPARATOR_MUX_ENABLE = 6;
    localparam int POS_REF_DIVIDER_LSB = 4;
    localparam int POS_REF_SOURCE_LSB = 6;
    localparam int POS_CHANNEL_SELECT_LSB = 0;
    localparam int POS_INTERNAL_REF_SELECT = 6;
    localparam int POS_COMPARE_RESULT_FLAG = 5;
    localparam int POS_POS_UNDEFINED = 0;
    localparam int POS_NEG_UNDEFINED = 1;

    // Reset values of the stored fields
    localparam logic RST_CONVERTER_ENABLE = 1'b0;
    localparam logic RST_COMPARATOR_MUX_ENABLE = 1'b0;
    localparam logic [1:0] RST_REF_DIVIDER = 2'h0;
    localparam logic [1:0] RST_REF_SOURCE = 2'h0;
    localparam logic [4:0] RST_CHANNEL_SELECT = 5'h00;
    localparam logic RST_INTERNAL_REF_SELECT = 1'b0;
    localparam logic [7:0] RST_READ_DATA = 8'h00;

    // Channel selection
    localparam int CHAN_W = 5;
    localparam int CHAN_COUNT = 11;
    localparam logic [4:0] CHAN_LAST = 5'h0a;

    // Reference source codes
    localparam logic [1:0] REF_SRC_LOW = 2'h1;
    localparam logic [1:0] REF_SRC_HIGH = 2'h3;

    // Divider codes: full, half, quarter, eighth scale
    localparam logic [1:0] DIV_FULL = 2'h0;

endpackage

// file: core/cis_pos_decode.sv
// Positive-side input decode of the comparator input selection block.
// Assumes its inputs are the register values about to be stored.
`timescale 1ns/1ps
`default_nettype none

module cis_pos_decode
    import cis_pkg::*;
(
    // Control fields
    input wire logic mux_enable,
    input wire logic conv_enable,
    input wire logic [CHAN_W-1:0] chan,
    // Decoded selection
    output logic use_mux,
    output logic [CHAN_COUNT-1:0] chan_onehot,
    output logic undefined
);

    // The converter mux may only feed the comparator while the converter is off
    assign use_mux = mux_enable & ~conv_enable;

    // Codes above the last channel have no meaning; flag them
    assign undefined = use_mux & (chan > CHAN_LAST);

    // One switch per analog channel; code 3 is the pin shared with the current source
    genvar g;
    generate
        for (g = 0; g < CHAN_COUNT; g = g + 1) begin : g_chan
            assign chan_onehot[g] = use_mux & (chan == CHAN_W'(g));
        end
    endgenerate

endmodule

`default_nettype wire

// file: core/cis_neg_decode.sv
// Negative-side input decode of the comparator input selection block.
// Assumes its inputs are the register values about to be stored.
`timescale 1ns/1ps
`default_nettype none

module cis_neg_decode
    import cis_pkg::*;
(
    // Control fields
    input wire logic iref,
    input wire logic [1:0] ref_src,
    input wire logic [1:0] ref_div,
    // Decoded selection
    output logic use_ref,
    output logic ref_high,
    output logic [1:0] div_out,
    output logic undefined
);

    // Default is the dedicated negative pin with the divider parked at full scale
    always_comb begin
        use_ref = 1'b0;
        ref_high = 1'b0;
        div_out = DIV_FULL;
        undefined = 1'b0;
        if (iref) begin
            case (ref_src)
                REF_SRC_LOW: begin
                    // Low reference is never divided
                    use_ref = 1'b1;
                end
                REF_SRC_HIGH: begin
                    // High reference scaled by the 2-bit divider
                    use_ref = 1'b1;
                    ref_high = 1'b1;
                    div_out = ref_div;
                end
                default: begin
                    // Undefined source: fall back to the pin and report it
                    undefined = 1'b1;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// file: core/cis_input_select.sv
// Top of the comparator input selection block: registers, decode, result.
// Assumes a simple synchronous register port driven on CLOCK, and an
// analog comparator whose raw output arrives on an unsynchronised pin.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Mux feeds positive input when enabled, converter off
// - Otherwise positive pin feeds positive input
// - Codes 0 to 10 pick channels 0 to 10
// - Reference select clear: negative pin, fields ignored
// - Source 01: undivided low reference
// - Source 11: divider picks high reference scale
// - High negative reference comes from 2-bit divider
// - Result flag set while positive exceeds negative
module cis_input_select
    import cis_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    // Analog comparator raw output
    input wire logic COMPARE_RAW,
    // Positive-side selection
    output logic POS_USE_MUX,
    output logic [CHAN_COUNT-1:0] POS_CHAN_EN,
    output logic POS_UNDEFINED,
    // Negative-side selection
    output logic NEG_USE_REF,
    output logic NEG_REF_HIGH,
    output logic [1:0] NEG_REF_DIV,
    output logic NEG_UNDEFINED,
    // Synchronised comparator result
    output logic COMPARE_RESULT
);

    // Every flip-flop of the block lives in this one record
    typedef struct packed {
        // Stored control fields
        logic conv_en;
        logic mux_en;
        logic [1:0] ref_div;
        logic [1:0] ref_src;
        logic [CHAN_W-1:0] chan;
        logic iref;
        // Result synchroniser stages
        logic sync_a;
        logic sync_b;
        // Read data, valid only the cycle after a read
        logic [DATA_W-1:0] rdata;
        // Registered copies of the decode
        logic pos_use_mux;
        logic [CHAN_COUNT-1:0] pos_chan_en;
        logic pos_undef;
        logic neg_use_ref;
        logic neg_ref_high;
        logic [1:0] neg_ref_div;
        logic neg_undef;
    } cis_state_t;

    // Reset image; the decode of all-zero fields is all zero as well
    localparam cis_state_t CIS_RESET = '{
        conv_en: RST_CONVERTER_ENABLE,
        mux_en: RST_COMPARATOR_MUX_ENABLE,
        ref_div: RST_REF_DIVIDER,
        ref_src: RST_REF_SOURCE,
        chan: RST_CHANNEL_SELECT,
        iref: RST_INTERNAL_REF_SELECT,
        sync_a: 1'b0,
        sync_b: 1'b0,
        rdata: RST_READ_DATA,
        pos_use_mux: 1'b0,
        pos_chan_en: '0,
        pos_undef: 1'b0,
        neg_use_ref: 1'b0,
        neg_ref_high: 1'b0,
        neg_ref_div: DIV_FULL,
        neg_undef: 1'b0
    };

    // Current and next state
    cis_state_t st_r;
    cis_state_t st_nxt;

    // Control fields after this cycle's write, fed to the decoders
    logic conv_en_nxt;
    logic mux_en_nxt;
    logic [1:0] ref_div_nxt;
    logic [1:0] ref_src_nxt;
    logic [CHAN_W-1:0] chan_nxt;
    logic iref_nxt;

    // Decoder results
    logic pos_use_mux;
    logic [CHAN_COUNT-1:0] pos_chan_en;
    logic pos_undef;
    logic neg_use_ref;
    logic neg_ref_high;
    logic [1:0] neg_ref_div;
    logic neg_undef;

    // Address match, shared by the write and read paths
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (a == off);
    endfunction

    // Write path: only mapped, writable fields change
    always_comb begin
        conv_en_nxt = st_r.conv_en;
        mux_en_nxt = st_r.mux_en;
        ref_div_nxt = st_r.ref_div;
        ref_src_nxt = st_r.ref_src;
        chan_nxt = st_r.chan;
        iref_nxt = st_r.iref;
        if (WR) begin
            if (reg_hit(ADDR, OFF_CONVERTER_CONTROL_A)) begin
                // Converter on/off steers the positive route
                conv_en_nxt = WDATA[POS_CONVERTER_ENABLE];
            end else if (reg_hit(ADDR, OFF_CONVERTER_CONTROL_B)) begin
                // Mux enable and divider code
                mux_en_nxt = WDATA[POS_COMPARATOR_MUX_ENABLE];
                ref_div_nxt = WDATA[POS_REF_DIVIDER_LSB +: 2];
            end else if (reg_hit(ADDR, OFF_CHANNEL_SELECT_REGISTER)) begin
                // Reference source and channel code share this register
                ref_src_nxt = WDATA[POS_REF_SOURCE_LSB +: 2];
                chan_nxt = WDATA[POS_CHANNEL_SELECT_LSB +: CHAN_W];
            end else if (reg_hit(ADDR, OFF_COMPARATOR_CONTROL_STATUS)) begin
                // Result flag is read-only; only the reference select is stored
                iref_nxt = WDATA[POS_INTERNAL_REF_SELECT];
            end
            // Writes to the status word or unmapped words are dropped
        end
    end

    // Positive-side decode of the values about to be stored
    cis_pos_decode u_pos (
        .mux_enable(mux_en_nxt),
        .conv_enable(conv_en_nxt),
        .chan(chan_nxt),
        .use_mux(pos_use_mux),
        .chan_onehot(pos_chan_en),
        .undefined(pos_undef)
    );

    // Negative-side decode of the values about to be stored
    cis_neg_decode u_neg (
        .iref(iref_nxt),
        .ref_src(ref_src_nxt),
        .ref_div(ref_div_nxt),
        .use_ref(neg_use_ref),
        .ref_high(neg_ref_high),
        .div_out(neg_ref_div),
        .undefined(neg_undef)
    );

    // Next state: fields, synchroniser, read data and registered decode
    always_comb begin
        st_nxt = st_r;

        // Stored control fields
        st_nxt.conv_en = conv_en_nxt;
        st_nxt.mux_en = mux_en_nxt;
        st_nxt.ref_div = ref_div_nxt;
        st_nxt.ref_src = ref_src_nxt;
        st_nxt.chan = chan_nxt;
        st_nxt.iref = iref_nxt;

        // Two-stage synchroniser; first stage feeds only the second
        st_nxt.sync_a = COMPARE_RAW;
        st_nxt.sync_b = st_r.sync_a;

        // Decode is taken from the next field values, so the registered
        // copy matches the stored fields in the same cycle; this keeps the
        // outputs glitch-free without adding a cycle of lag
        st_nxt.pos_use_mux = pos_use_mux;
        st_nxt.pos_chan_en = pos_chan_en;
        // A code above ten drives no channel switch at all
        st_nxt.pos_undef = pos_undef;
        // With the reference select clear the divider fields are ignored
        st_nxt.neg_use_ref = neg_use_ref;
        st_nxt.neg_ref_high = neg_ref_high;
        st_nxt.neg_ref_div = neg_ref_div;
        st_nxt.neg_undef = neg_undef;

        // Read data stand only in the cycle after the read strobe
        st_nxt.rdata = '0;
        if (RD) begin
            if (reg_hit(ADDR, OFF_CONVERTER_CONTROL_A)) begin
                // Converter enable in the top bit
                st_nxt.rdata[POS_CONVERTER_ENABLE] = st_r.conv_en;
            end else if (reg_hit(ADDR, OFF_CONVERTER_CONTROL_B)) begin
                // Mux enable and divider code
                st_nxt.rdata[POS_COMPARATOR_MUX_ENABLE] = st_r.mux_en;
                st_nxt.rdata[POS_REF_DIVIDER_LSB +: 2] = st_r.ref_div;
            end else if (reg_hit(ADDR, OFF_CHANNEL_SELECT_REGISTER)) begin
                // Reference source and channel code
                st_nxt.rdata[POS_REF_SOURCE_LSB +: 2] = st_r.ref_src;
                st_nxt.rdata[POS_CHANNEL_SELECT_LSB +: CHAN_W] = st_r.chan;
            end else if (reg_hit(ADDR, OFF_COMPARATOR_CONTROL_STATUS)) begin
                // Reference select and the synchronised result
                st_nxt.rdata[POS_INTERNAL_REF_SELECT] = st_r.iref;
                st_nxt.rdata[POS_COMPARE_RESULT_FLAG] = st_r.sync_b;
            end else if (reg_hit(ADDR, OFF_SELECT_STATUS)) begin
                // Undefined selections, so software can spot a bad setup
                st_nxt.rdata[POS_POS_UNDEFINED] = st_r.pos_undef;
                st_nxt.rdata[POS_NEG_UNDEFINED] = st_r.neg_undef;
            end
            // Unmapped words read as zero
        end
    end

    // State register with synchronous reset to the constant image
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            st_r <= CIS_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state record
    assign RDATA = st_r.rdata;
    assign POS_USE_MUX = st_r.pos_use_mux;
    assign POS_CHAN_EN = st_r.pos_chan_en;
    assign POS_UNDEFINED = st_r.pos_undef;
    assign NEG_USE_REF = st_r.neg_use_ref;
    assign NEG_REF_HIGH = st_r.neg_ref_high;
    assign NEG_REF_DIV = st_r.neg_ref_div;
    assign NEG_UNDEFINED = st_r.neg_undef;
    // Result lags the raw comparator by one to two clocks
    assign COMPARE_RESULT = st_r.sync_b;

endmodule

`default_nettype wire

// file: verif/cis_monitor.sv
// Port checker of the comparator input selection block.
// Assumes it is bound to cis_input_select and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cis_monitor
    import cis_pkg::*;
(
    // Clock, reset and register port
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA,
    // Comparator and selections
    input wire logic COMPARE_RAW,
    input wire logic POS_USE_MUX,
    input wire logic [CHAN_COUNT-1:0] POS_CHAN_EN,
    input wire logic POS_UNDEFINED,
    input wire logic NEG_USE_REF,
    input wire logic NEG_REF_HIGH,
    input wire logic [1:0] NEG_REF_DIV,
    input wire logic NEG_UNDEFINED,
    input wire logic COMPARE_RESULT
);
    // One domain, so one clock and one reset for all
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // Mux route only ever appears through a register write
    property p_mux_by_write; $rose(POS_USE_MUX) |-> $past(WR); endproperty
    property p_conv_on_pin;
        WR && ADDR == OFF_CONVERTER_CONTROL_A && WDATA[POS_CONVERTER_ENABLE] |=> !POS_USE_MUX;
    endproperty
    property p_mux_off_pin;
        WR && ADDR == OFF_CONVERTER_CONTROL_B && !WDATA[POS_COMPARATOR_MUX_ENABLE] |=> !POS_USE_MUX;
    endproperty
    property p_chan_onehot; POS_USE_MUX && !POS_UNDEFINED |-> $onehot(POS_CHAN_EN); endproperty
    property p_pin_no_chan; !POS_USE_MUX |-> POS_CHAN_EN == '0 && !POS_UNDEFINED; endproperty
    property p_neg_pin;
        WR && ADDR == OFF_COMPARATOR_CONTROL_STATUS && !WDATA[POS_INTERNAL_REF_SELECT]
            |=> !NEG_USE_REF && !NEG_UNDEFINED;
    endproperty
    property p_low_undiv; NEG_USE_REF && !NEG_REF_HIGH |-> NEG_REF_DIV == DIV_FULL; endproperty
    property p_ref_off; !NEG_USE_REF |-> !NEG_REF_HIGH && NEG_REF_DIV == DIV_FULL; endproperty
    // Two flops of synchroniser; skip edges that still see reset-time flops
    property p_result_sync;
        $past(NRST) && $past(NRST, 2) |-> COMPARE_RESULT == $past(COMPARE_RAW, 2);
    endproperty
    property p_undef_safe; POS_UNDEFINED |-> POS_USE_MUX && POS_CHAN_EN == '0; endproperty
    a_mux_by_write: assert property (p_mux_by_write) else $error("mux route without write");
    a_conv_on_pin: assert property (p_conv_on_pin) else $error("mux kept with converter on");
    a_mux_off_pin: assert property (p_mux_off_pin) else $error("mux kept when disabled");
    a_chan_onehot: assert property (p_chan_onehot) else $error("channel switch not one-hot");
    a_pin_no_chan: assert property (p_pin_no_chan) else $error("channel on with pin route");
    a_neg_pin: assert property (p_neg_pin) else $error("reference kept when deselected");
    a_low_undiv: assert property (p_low_undiv) else $error("low reference divided");
    a_ref_off: assert property (p_ref_off) else $error("reference fields leak to pin");
    a_result_sync: assert property (p_result_sync) else $error("result latency wrong");
    a_undef_safe: assert property (p_undef_safe) else $error("undefined code not safe");
    // Main scenarios reached
    c_last_chan: cover property (POS_USE_MUX && POS_CHAN_EN[CHAN_COUNT-1]);
    c_eighth: cover property (NEG_REF_HIGH && NEG_REF_DIV == 2'h3);
    c_result_up: cover property ($rose(COMPARE_RESULT));
endmodule
bind cis_input_select cis_monitor i_cis_monitor (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .COMPARE_RAW(COMPARE_RAW),
    .POS_USE_MUX(POS_USE_MUX), .POS_CHAN_EN(POS_CHAN_EN), .POS_UNDEFINED(POS_UNDEFINED),
    .NEG_USE_REF(NEG_USE_REF), .NEG_REF_HIGH(NEG_REF_HIGH), .NEG_REF_DIV(NEG_REF_DIV),
    .NEG_UNDEFINED(NEG_UNDEFINED), .COMPARE_RESULT(COMPARE_RESULT));
`default_nettype wire

// file: verif/cis_comparator_model.sv
// Behavioural analog comparator with its input multiplexers.
// Assumes voltages in millivolts from the bench, selections from the block.
`timescale 1ns/1ps
`default_nettype none
module cis_comparator_model
    import cis_pkg::*;
(
    // Selections from the block
    input wire logic pos_use_mux,
    input wire logic [CHAN_COUNT-1:0] pos_chan_en,
    input wire logic neg_use_ref,
    input wire logic neg_ref_high,
    input wire logic [1:0] neg_ref_div,
    // Pin and channel voltages
    input wire logic [11:0] v_pos_pin,
    input wire logic [11:0] v_neg_pin,
    input wire logic [11:0] v_chan [CHAN_COUNT],
    // Raw decision, unsynchronised
    output logic compare_raw
);
    logic [11:0] v_pos; // Voltage seen on the positive input
    logic [11:0] v_neg; // Voltage seen on the negative input
    // Instant analog decision; the block alone must synchronise it
    always_comb begin
        v_pos = v_pos_pin;
        for (int n = 0; n < CHAN_COUNT; n++) begin
            if (pos_use_mux && pos_chan_en[n]) begin
                v_pos = v_chan[n];
            end
        end
        v_neg = v_neg_pin;
        if (neg_use_ref) begin
            v_neg = neg_ref_high ? (12'ha00 >> neg_ref_div) : 12'h44c;
        end
        compare_raw = v_pos > v_neg;
    end
endmodule
`default_nettype wire

// file: verif/cis_input_select_tb.sv
// Self-checking bench of the comparator input selection block.
// Assumes the comparator model beside it and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module cis_input_select_tb
    import cis_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic raw, use_mux, pos_und, use_ref, ref_high, neg_und, result;
    logic [10:0] chan_en;
    logic [1:0] ref_div;
    logic [11:0] v_pos_pin = 12'h001;
    logic [11:0] v_neg_pin = 12'h7ff;
    logic [11:0] v_chan [CHAN_COUNT] = '{default: 12'h001};
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    // Block under test and the comparator behind it
    cis_input_select i_cis_input_select (.CLOCK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .COMPARE_RAW(raw), .POS_USE_MUX(use_mux),
        .POS_CHAN_EN(chan_en), .POS_UNDEFINED(pos_und), .NEG_USE_REF(use_ref),
        .NEG_REF_HIGH(ref_high), .NEG_REF_DIV(ref_div), .NEG_UNDEFINED(neg_und),
        .COMPARE_RESULT(result));
    cis_comparator_model i_cis_comparator_model (.pos_use_mux(use_mux), .pos_chan_en(chan_en),
        .neg_use_ref(use_ref), .neg_ref_high(ref_high), .neg_ref_div(ref_div),
        .v_pos_pin(v_pos_pin), .v_neg_pin(v_neg_pin), .v_chan(v_chan), .compare_raw(raw));
    // Clock of 10 ns
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobes drop with a cycle gap, so back-to-back calls never collide
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
        @(posedge clk);
    endtask
    // Packed as {undefined, mux route, channel switches}
    function automatic logic [15:0] exp_pos(input logic route, input logic [4:0] ch);
        if (!route) return 16'h0000;
        if (ch > 5'h0a) return 16'h1800;
        return 16'h0800 | (16'h0001 << ch);
    endfunction
    // Packed as {undefined, reference, high, divider}
    function automatic logic [15:0] exp_neg(input logic ir, input logic [1:0] s, input logic [1:0] d);
        if (!ir) return 16'h0000;
        if (s == 2'h1) return 16'h0008;
        if (s == 2'h3) return 16'h000c | {14'h0000, d};
        return 16'h0010;
    endfunction
    task automatic results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        logic [31:0] cfg;
        logic [4:0] ch;
        logic [11:0] vp;
        logic [11:0] vn;
        void'($urandom(32'hb840c349));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Everything reads zero after reset, unmapped place too
        for (int a = 0; a < 6; a++) begin
            rd_chk(a[2:0], 8'h00);
        end
        // Every enable pair against every channel code, undefined ones too
        for (int k = 0; k < 128; k++) begin
            wr_reg(OFF_CONVERTER_CONTROL_A, {k[6], 7'h00});
            wr_reg(OFF_CONVERTER_CONTROL_B, {1'b0, k[5], 6'h00});
            wr_reg(OFF_CHANNEL_SELECT_REGISTER, {3'h0, k[4:0]});
            chk({3'h0, pos_und, use_mux, chan_en}, exp_pos(k[5] && !k[6], k[4:0]));
            rd_chk(OFF_SELECT_STATUS, {7'h00, k[5] && !k[6] && k[4:0] > 5'h0a});
        end
        // Every reference select, source and divider combination
        for (int k = 0; k < 32; k++) begin
            wr_reg(OFF_COMPARATOR_CONTROL_STATUS, {1'b0, k[4], 6'h3f});
            wr_reg(OFF_CONVERTER_CONTROL_B, {2'h0, k[1:0], 4'h0});
            wr_reg(OFF_CHANNEL_SELECT_REGISTER, {k[3:2], 6'h00});
            chk({11'h000, neg_und, use_ref, ref_high, ref_div}, exp_neg(k[4], k[3:2], k[1:0]));
            rd_chk(OFF_SELECT_STATUS, {6'h00, k[4] && !k[2], 1'b0});
        end
        // Random voltages and settings, odd voltages never tie a reference
        for (int k = 0; k < 60; k++) begin
            cfg = $urandom;
            // Software never programs a code above ten while the mux may be routed
            ch = 5'(cfg[11:8] % 11);
            v_pos_pin <= 12'h001 | 12'($urandom % 3000);
            v_neg_pin <= 12'h001 | 12'($urandom % 3000);
            for (int n = 0; n < CHAN_COUNT; n++) begin
                v_chan[n] <= 12'h001 | 12'($urandom % 3000);
            end
            wr_reg(OFF_CONVERTER_CONTROL_A, {cfg[1], 7'h00});
            wr_reg(OFF_CONVERTER_CONTROL_B, {1'b0, cfg[0], cfg[6:5], 4'h0});
            wr_reg(OFF_CHANNEL_SELECT_REGISTER, {cfg[4:3], 1'b0, ch});
            wr_reg(OFF_COMPARATOR_CONTROL_STATUS, {1'b0, cfg[2], 6'h00});
            vp = (cfg[0] && !cfg[1]) ? v_chan[ch] : v_pos_pin;
            vn = v_neg_pin;
            if (cfg[2] && cfg[4:3] == 2'h1) vn = 12'h44c;
            if (cfg[2] && cfg[4:3] == 2'h3) vn = 12'ha00 >> cfg[6:5];
            repeat (3) @(posedge clk);
            rd_chk(OFF_COMPARATOR_CONTROL_STATUS, {1'b0, cfg[2], vp > vn, 5'h00});
        end
        // Reset in mid-run clears every selection and the result
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        #1 chk({3'h0, pos_und, use_mux, chan_en}, 16'h0000);
        chk({10'h000, neg_und, use_ref, ref_high, ref_div, result}, 16'h0000);
        results();
    end
endmodule
`default_nettype wire
